// ### hdl/regsem_bank.sv
// register bank with per-field access behaviour and four host-visible queues
`timescale 1ns/1ps
`default_nettype none
module regsem_bank (
  // clock and reset
  input  wire logic                            CLOCK,
  input  wire logic                            RESET,
  // host register access
  input  wire logic [regsem_pkg::ADDR_W-1:0]   HOST_ADDR,
  input  wire logic                            HOST_RD,
  input  wire logic                            HOST_WR,
  input  wire logic [regsem_pkg::DATA_W-1:0]   HOST_WDATA,
  output logic      [regsem_pkg::DATA_W-1:0]   HOST_RDATA,
  output logic                                 HOST_RVALID,
  // receive path feed
  input  wire logic                            RXS_VALID,
  input  wire logic [regsem_pkg::DATA_W-1:0]   RXS_DATA,
  output logic                                 RXS_READY,
  input  wire logic                            RXD_VALID,
  input  wire logic [regsem_pkg::DATA_W-1:0]   RXD_DATA,
  output logic                                 RXD_READY,
  // transmit path
  input  wire logic                            TXS_VALID,
  input  wire logic [regsem_pkg::DATA_W-1:0]   TXS_DATA,
  output logic                                 TXS_READY,
  output logic                                 TXD_VALID,
  output logic      [regsem_pkg::DATA_W-1:0]   TXD_DATA,
  input  wire logic                            TXD_READY,
  // status pins from outside the clock domain
  input  wire logic                            LINK_UP,
  input  wire logic                            FAULT,
  input  wire logic [regsem_pkg::EVT_W-1:0]    EVENT_W1C,
  input  wire logic [regsem_pkg::EVT_W-1:0]    EVENT_RC,
  // register values steering the rest of the chip
  output logic      [regsem_pkg::DATA_W-1:0]   COMMAND_WORD,
  output logic      [regsem_pkg::DATA_W-1:0]   RETAINED_WORD,
  output logic                                 SOFT_RESET
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic                            link_s1;
    logic                            link_s2;
    logic                            fault_s1;
    logic                            fault_s2;
    logic [regsem_pkg::EVT_W-1:0]    w1c_s1;
    logic [regsem_pkg::EVT_W-1:0]    w1c_s2;
    logic [regsem_pkg::EVT_W-1:0]    rc_s1;
    logic [regsem_pkg::EVT_W-1:0]    rc_s2;
    logic                            srst_pend;
    logic [regsem_pkg::CAP_W-1:0]    cap_rxs;
    logic [regsem_pkg::CAP_W-1:0]    cap_rxd;
    logic [regsem_pkg::CAP_W-1:0]    cap_txd;
    logic [regsem_pkg::DATA_W-1:0]   retained;
    logic [regsem_pkg::EVT_W-1:0]    evt_w1c;
    logic [regsem_pkg::EVT_W-1:0]    evt_rc;
    logic                            link_ll;
    logic                            fault_lh;
    logic [regsem_pkg::DATA_W-1:0]   cmd_word;
    logic [regsem_pkg::DATA_W-1:0]   rdata;
    logic                            rvalid;
  } state_t;

  // the link synchroniser starts at the up level, so no false low is latched out of reset
  localparam state_t RST_STATE = '{
    link_s1: 1'b1,
    link_s2: 1'b1,
    cap_rxs: regsem_pkg::CAP_DEFAULT,
    cap_rxd: regsem_pkg::CAP_DEFAULT,
    cap_txd: regsem_pkg::CAP_DEFAULT,
    link_ll: 1'b1,
    default: '0
  };

  state_t                          s_reg;
  state_t                          s_next;
  logic [regsem_pkg::DATA_W-1:0]   read_word;
  logic [1:0]                      page;
  logic                            rd_rxs_pop;
  logic                            rd_txs_pop;
  logic                            rd_rxd;
  logic                            rxs_valid_q;
  logic                            rxd_valid_q;
  logic                            txs_valid_q;
  logic [regsem_pkg::DATA_W-1:0]   rxs_head;
  logic [regsem_pkg::DATA_W-1:0]   rxd_head;
  logic [regsem_pkg::DATA_W-1:0]   txs_head;
  logic                            txd_push_ready;
  logic [regsem_pkg::QCNT_W-1:0]   rxs_cnt;
  logic [regsem_pkg::QCNT_W-1:0]   rxd_cnt;
  logic [regsem_pkg::QCNT_W-1:0]   txs_cnt;
  logic [regsem_pkg::QCNT_W-1:0]   txd_cnt;
  logic                            host_rd;
  logic                            host_wr;

  // host access is ignored during the one soft-reset cycle
  assign host_rd    = HOST_RD && !s_reg.srst_pend;
  assign host_wr    = HOST_WR && !s_reg.srst_pend;
  assign page       = HOST_ADDR[regsem_pkg::PAGE_MSB:regsem_pkg::PAGE_LSB];
  // every word of the receive data page reaches the queue head
  assign rd_rxd     = host_rd && (page == regsem_pkg::PAGE_RXD);
  assign rd_rxs_pop = host_rd && (HOST_ADDR == regsem_pkg::ADDR_RXS_POP);
  assign rd_txs_pop = host_rd && (HOST_ADDR == regsem_pkg::ADDR_TXS_POP);

  // ****************************************************************
  // the four host-visible queues
  // ****************************************************************
  regsem_queue #(.WIDTH(regsem_pkg::DATA_W)) u_rxs (
    .clk(CLOCK), .rst(RESET), .clr(s_reg.srst_pend), .cap(s_reg.cap_rxs),
    .in_valid(RXS_VALID), .in_data(RXS_DATA), .in_ready(RXS_READY),
    .out_pop(rd_rxs_pop), .out_valid(rxs_valid_q), .out_data(rxs_head), .count(rxs_cnt));

  regsem_queue #(.WIDTH(regsem_pkg::DATA_W)) u_rxd (
    .clk(CLOCK), .rst(RESET), .clr(s_reg.srst_pend), .cap(s_reg.cap_rxd),
    .in_valid(RXD_VALID), .in_data(RXD_DATA), .in_ready(RXD_READY),
    .out_pop(rd_rxd), .out_valid(rxd_valid_q), .out_data(rxd_head), .count(rxd_cnt));

  // transmit status depth is fixed: its capacity is not host-set
  regsem_queue #(.WIDTH(regsem_pkg::DATA_W)) u_txs (
    .clk(CLOCK), .rst(RESET), .clr(s_reg.srst_pend), .cap(regsem_pkg::CAP_DEFAULT),
    .in_valid(TXS_VALID), .in_data(TXS_DATA), .in_ready(TXS_READY),
    .out_pop(rd_txs_pop), .out_valid(txs_valid_q), .out_data(txs_head), .count(txs_cnt));

  // host writes to a full transmit data queue are dropped
  regsem_queue #(.WIDTH(regsem_pkg::DATA_W)) u_txd (
    .clk(CLOCK), .rst(RESET), .clr(s_reg.srst_pend), .cap(s_reg.cap_txd),
    .in_valid(host_wr && (page == regsem_pkg::PAGE_TXD)), .in_data(HOST_WDATA),
    .in_ready(txd_push_ready), .out_pop(TXD_READY), .out_valid(TXD_VALID),
    .out_data(TXD_DATA), .count(txd_cnt));

  // ****************************************************************
  // read data selection
  // ****************************************************************
  always_comb begin
    read_word = regsem_pkg::RESERVED_VALUE;
    if (page == regsem_pkg::PAGE_RXD) begin
      read_word = rxd_valid_q ? rxd_head : regsem_pkg::ZERO_WORD;
    end else if (page == regsem_pkg::PAGE_TXD) begin
      read_word = regsem_pkg::ZERO_WORD;
    end else begin
      case (HOST_ADDR)
        regsem_pkg::ADDR_RXS_POP,
        regsem_pkg::ADDR_RXS_PEEK: read_word = rxs_valid_q ? rxs_head : regsem_pkg::ZERO_WORD;
        regsem_pkg::ADDR_TXS_POP,
        regsem_pkg::ADDR_TXS_PEEK: read_word = txs_valid_q ? txs_head : regsem_pkg::ZERO_WORD;
        regsem_pkg::ADDR_IDENT:    read_word = regsem_pkg::IDENT_VALUE;
        regsem_pkg::ADDR_CONFIG: begin
          read_word[regsem_pkg::CFG_SRST_BIT] = s_reg.srst_pend;
          read_word[regsem_pkg::CFG_RXD_LSB +: regsem_pkg::CAP_W] = s_reg.cap_rxd;
          read_word[regsem_pkg::CFG_RXS_LSB +: regsem_pkg::CAP_W] = s_reg.cap_rxs;
          read_word[regsem_pkg::CFG_TXD_LSB +: regsem_pkg::CAP_W] = s_reg.cap_txd;
        end
        regsem_pkg::ADDR_RETAIN:   read_word = s_reg.retained;
        regsem_pkg::ADDR_EVT_W1C:  read_word[regsem_pkg::EVT_W-1:0] = s_reg.evt_w1c;
        regsem_pkg::ADDR_EVT_RC:   read_word[regsem_pkg::EVT_W-1:0] = s_reg.evt_rc;
        regsem_pkg::ADDR_LINK: begin
          read_word[regsem_pkg::LINK_LL_BIT] = s_reg.link_ll;
          read_word[regsem_pkg::LINK_LH_BIT] = s_reg.fault_lh;
        end
        regsem_pkg::ADDR_COMMAND:  read_word = regsem_pkg::ZERO_WORD;
        regsem_pkg::ADDR_LEVELS: begin
          read_word[regsem_pkg::LVL_RXS_LSB +: regsem_pkg::QCNT_W] = rxs_cnt;
          read_word[regsem_pkg::LVL_RXD_LSB +: regsem_pkg::QCNT_W] = rxd_cnt;
          read_word[regsem_pkg::LVL_TXS_LSB +: regsem_pkg::QCNT_W] = txs_cnt;
          read_word[regsem_pkg::LVL_TXD_LSB +: regsem_pkg::QCNT_W] = txd_cnt;
        end
        default:                   read_word = regsem_pkg::RESERVED_VALUE;
      endcase
    end
  end

  // ****************************************************************
  // next state: synchronisers, field behaviour, soft reset
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    // two flops on every pin; only the second stage feeds logic
    s_next.link_s1  = LINK_UP;
    s_next.link_s2  = s_reg.link_s1;
    s_next.fault_s1 = FAULT;
    s_next.fault_s2 = s_reg.fault_s1;
    s_next.w1c_s1   = EVENT_W1C;
    s_next.w1c_s2   = s_reg.w1c_s1;
    s_next.rc_s1    = EVENT_RC;
    s_next.rc_s2    = s_reg.rc_s1;
    s_next.rvalid   = host_rd;
    if (host_rd) s_next.rdata = read_word;
    // writes land only on writable fields; identity, levels, status ports and
    // reserved words have no write path at all
    if (host_wr) begin
      case (HOST_ADDR)
        regsem_pkg::ADDR_CONFIG: begin
          s_next.srst_pend = HOST_WDATA[regsem_pkg::CFG_SRST_BIT];
          s_next.cap_rxd = HOST_WDATA[regsem_pkg::CFG_RXD_LSB +: regsem_pkg::CAP_W];
          s_next.cap_rxs = HOST_WDATA[regsem_pkg::CFG_RXS_LSB +: regsem_pkg::CAP_W];
          s_next.cap_txd = HOST_WDATA[regsem_pkg::CFG_TXD_LSB +: regsem_pkg::CAP_W];
        end
        regsem_pkg::ADDR_RETAIN:  s_next.retained = HOST_WDATA;
        regsem_pkg::ADDR_COMMAND: s_next.cmd_word = HOST_WDATA;
        default:                  s_next.cmd_word = s_reg.cmd_word;
      endcase
    end
    // write one clears, zero leaves; a new event in the same cycle wins
    if (host_wr && (HOST_ADDR == regsem_pkg::ADDR_EVT_W1C)) begin
      s_next.evt_w1c = (s_reg.evt_w1c & ~HOST_WDATA[regsem_pkg::EVT_W-1:0]) | s_reg.w1c_s2;
    end else begin
      s_next.evt_w1c = s_reg.evt_w1c | s_reg.w1c_s2;
    end
    // the read returns the old value and clears behind it; a new event still lands
    if (host_rd && (HOST_ADDR == regsem_pkg::ADDR_EVT_RC)) begin
      s_next.evt_rc = s_reg.rc_s2;
    end else begin
      s_next.evt_rc = s_reg.evt_rc | s_reg.rc_s2;
    end
    // a read releases both latches to the live condition, so a condition still
    // present is never lost
    if (host_rd && (HOST_ADDR == regsem_pkg::ADDR_LINK)) begin
      s_next.link_ll  = s_reg.link_s2;
      s_next.fault_lh = s_reg.fault_s2;
    end else begin
      s_next.link_ll  = s_reg.link_ll & s_reg.link_s2;
      s_next.fault_lh = s_reg.fault_lh | s_reg.fault_s2;
    end
    // soft reset lasts one cycle, then its bit falls by itself
    if (s_reg.srst_pend) begin
      s_next          = RST_STATE;
      s_next.retained = s_reg.retained;
      s_next.link_s1  = LINK_UP;
      s_next.link_s2  = s_reg.link_s1;
      s_next.fault_s1 = FAULT;
      s_next.fault_s2 = s_reg.fault_s1;
      s_next.w1c_s1   = EVENT_W1C;
      s_next.w1c_s2   = s_reg.w1c_s1;
      s_next.rc_s1    = EVENT_RC;
      s_next.rc_s2    = s_reg.rc_s1;
    end
  end

  // system reset loads every default, the exempt word included
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) s_reg <= RST_STATE;
    else       s_reg <= s_next;
  end

  // outputs, all from flops
  assign HOST_RDATA    = s_reg.rdata;
  assign HOST_RVALID   = s_reg.rvalid;
  assign COMMAND_WORD  = s_reg.cmd_word;
  assign RETAINED_WORD = s_reg.retained;
  assign SOFT_RESET    = s_reg.srst_pend;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_ro_status_write: assert property (
    host_wr && !host_rd && HOST_ADDR == regsem_pkg::ADDR_RXS_POP && !(RXS_VALID && RXS_READY)
    |=> rxs_cnt == $past(rxs_cnt))
    else $error("write to a read-only status port changed the queue");
  a_wo_read_zero: assert property (
    host_rd && (page == regsem_pkg::PAGE_TXD || HOST_ADDR == regsem_pkg::ADDR_COMMAND)
    |=> HOST_RVALID && HOST_RDATA == regsem_pkg::ZERO_WORD)
    else $error("write-only location did not read as zero");
  a_w1c_clear_bit: assert property (
    host_wr && HOST_ADDR == regsem_pkg::ADDR_EVT_W1C && HOST_WDATA[0] && !s_reg.w1c_s2[0]
    |=> !s_reg.evt_w1c[0])
    else $error("write of one did not clear the bit");
  a_w1c_zero_keeps: assert property (
    host_wr && HOST_ADDR == regsem_pkg::ADDR_EVT_W1C && !HOST_WDATA[0] && s_reg.evt_w1c[0]
    |=> s_reg.evt_w1c[0])
    else $error("write of zero cleared the bit");
  a_rc_read_clears: assert property (
    host_rd && HOST_ADDR == regsem_pkg::ADDR_EVT_RC && s_reg.rc_s2 == '0
    |=> s_reg.evt_rc == '0 && HOST_RDATA[regsem_pkg::EVT_W-1:0] == $past(s_reg.evt_rc))
    else $error("read-to-clear bits not returned then cleared");
  a_ll_holds_low: assert property (
    !s_reg.link_s2 && !s_reg.srst_pend
    ##1 (s_reg.link_s2 && !(host_rd && HOST_ADDR == regsem_pkg::ADDR_LINK) && !s_reg.srst_pend)
    |=> !s_reg.link_ll)
    else $error("latch-low bit did not hold a past low");
  a_lh_holds_high: assert property (
    s_reg.fault_s2 && !s_reg.srst_pend |=> s_reg.fault_lh)
    else $error("latch-high bit missed a high condition");
  a_exempt_kept: assert property (
    s_reg.srst_pend |=> RETAINED_WORD == $past(RETAINED_WORD))
    else $error("exempt field changed on soft reset");
  a_defaults_loaded: assert property (
    s_reg.srst_pend |=> s_reg.cap_rxd == regsem_pkg::CAP_DEFAULT && COMMAND_WORD == regsem_pkg::ZERO_WORD
                        && rxs_cnt == '0 && txd_cnt == '0)
    else $error("soft reset did not load defaults");
  a_self_clear: assert property (
    s_reg.srst_pend |=> !s_reg.srst_pend)
    else $error("soft reset bit did not clear itself");
  a_peek_no_pop: assert property (
    host_rd && HOST_ADDR == regsem_pkg::ADDR_TXS_PEEK && txs_valid_q && !(TXS_VALID && TXS_READY)
    |=> txs_cnt == $past(txs_cnt) && HOST_RDATA == $past(txs_head))
    else $error("peek changed the transmit status queue");
  a_alias_pops: assert property (
    rd_rxd && rxd_valid_q && !(RXD_VALID && RXD_READY)
    |=> rxd_cnt == $past(rxd_cnt) - 1'b1 && HOST_RDATA == $past(rxd_head))
    else $error("aliased data read did not pop the head");

  c_rxs_pop_read: cover property (rd_rxs_pop && rxs_valid_q);
  c_txd_full: cover property (!txd_push_ready && !s_reg.srst_pend);
  c_soft_reset: cover property (s_reg.srst_pend);
  c_w1c_set_wins: cover property (host_wr && HOST_ADDR == regsem_pkg::ADDR_EVT_W1C && s_reg.w1c_s2 != '0);

endmodule : regsem_bank
`default_nettype wire

// ### hdl/regsem_queue.sv
// one host-visible queue with a host-set capacity limit
`timescale 1ns/1ps
`default_nettype none
module regsem_queue #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          clr,
  // capacity, entries minus one
  input  wire logic [regsem_pkg::CAP_W-1:0]  cap,
  // filling side
  input  wire logic                          in_valid,
  input  wire logic [WIDTH-1:0]              in_data,
  output logic                               in_ready,
  // draining side
  input  wire logic                          out_pop,
  output logic                               out_valid,
  output logic [WIDTH-1:0]                   out_data,
  output logic [regsem_pkg::QCNT_W-1:0]      count
);

  typedef struct packed {
    logic [regsem_pkg::QPTR_W-1:0] wptr;
    logic [regsem_pkg::QPTR_W-1:0] rptr;
    logic [regsem_pkg::QCNT_W-1:0] cnt;
  } qstate_t;

  qstate_t          q_reg;
  qstate_t          q_next;
  logic [WIDTH-1:0] mem [0:regsem_pkg::QDEPTH-1];
  logic             push;
  logic             pop;

  // a lowered capacity below the fill level just holds the queue full until drained
  assign in_ready  = !clr && (q_reg.cnt <= {1'b0, cap});
  assign out_valid = (q_reg.cnt != '0);
  assign out_data  = mem[q_reg.rptr];
  assign count     = q_reg.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_pop && out_valid && !clr;

  // ****************************************************************
  // pointer and count update
  // ****************************************************************
  always_comb begin
    q_next = q_reg;
    if (clr) begin
      q_next = '0;
    end else begin
      if (push) q_next.wptr = q_reg.wptr + 1'b1;
      if (pop)  q_next.rptr = q_reg.rptr + 1'b1;
      q_next.cnt = q_reg.cnt + {{(regsem_pkg::QCNT_W-1){1'b0}}, push} - {{(regsem_pkg::QCNT_W-1){1'b0}}, pop};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) q_reg <= '0;
    else     q_reg <= q_next;
  end

  // storage has no reset: only entries below the count are ever read
  always_ff @(posedge clk) begin
    if (push) mem[q_reg.wptr] <= in_data;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_queue_capacity: assert property (push |-> q_reg.cnt <= {1'b0, cap})
    else $error("queue accepted an entry beyond its capacity");
  a_queue_pop_count: assert property (pop && !push |=> q_reg.cnt == $past(q_reg.cnt) - 1'b1)
    else $error("queue pop did not remove exactly one entry");

endmodule : regsem_queue
`default_nettype wire

// ### include/regsem_pkg.sv
// constants shared by the register-bank with host-visible queues
//
// Summary of operation
// - A host write to a read-only location or field is ignored and leaves the contents unchanged.
// - A host read of a write-only location always returns zero.
// - Writing one to a write-one-to-clear bit clears it, writing zero leaves it, and the bit stays readable.
// - A read-to-clear bit returns its value to the host and is then reset to zero by that read.
// - A latch-low bit holds a low condition after it has gone away until the host reads its register.
// - A latch-high bit holds a high condition after it has gone away until the host reads its register.
// - Fields exempt from software reset keep their values through a software reset.
// - System reset loads every register with its default value; software reset does too, except for the exempt fields.
// - Four queues face the host: receive status, receive data, transmit status and transmit data.
// - The capacity of both data queues and of the receive status queue is set by the host.
// - Each status queue has a pop port that removes the head and a peek port that leaves it.
// - Each data queue port is aliased over 16 word locations; receive data reads reach the queue head, transmit data writes push onto the queue tail.
package regsem_pkg;

  // ****************************************************************
  // widths and queue geometry
  // ****************************************************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int EVT_W  = 4;
  localparam int QDEPTH = 16;
  localparam int QPTR_W = 4;
  localparam int QCNT_W = 5;
  localparam int CAP_W  = 4;

  // ****************************************************************
  // address map, word addresses
  // ****************************************************************
  localparam int          PAGE_MSB   = 5;
  localparam int          PAGE_LSB   = 4;
  localparam logic [1:0]  PAGE_RXD   = 2'h0;  // 16 aliased receive data words
  localparam logic [1:0]  PAGE_TXD   = 2'h1;  // 16 aliased transmit data words
  localparam logic [5:0]  ADDR_RXS_POP  = 6'h20;
  localparam logic [5:0]  ADDR_RXS_PEEK = 6'h21;
  localparam logic [5:0]  ADDR_TXS_POP  = 6'h22;
  localparam logic [5:0]  ADDR_TXS_PEEK = 6'h23;
  localparam logic [5:0]  ADDR_IDENT    = 6'h24;
  localparam logic [5:0]  ADDR_CONFIG   = 6'h25;
  localparam logic [5:0]  ADDR_RETAIN   = 6'h26;
  localparam logic [5:0]  ADDR_EVT_W1C  = 6'h27;
  localparam logic [5:0]  ADDR_EVT_RC   = 6'h28;
  localparam logic [5:0]  ADDR_LINK     = 6'h29;
  localparam logic [5:0]  ADDR_COMMAND  = 6'h2a;
  localparam logic [5:0]  ADDR_LEVELS   = 6'h2b;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CFG_SRST_BIT = 0;
  localparam int CFG_RXD_LSB  = 4;
  localparam int CFG_RXS_LSB  = 8;
  localparam int CFG_TXD_LSB  = 12;
  localparam int LINK_LL_BIT  = 0;
  localparam int LINK_LH_BIT  = 1;
  localparam int LVL_RXS_LSB  = 0;
  localparam int LVL_RXD_LSB  = 8;
  localparam int LVL_TXS_LSB  = 16;
  localparam int LVL_TXD_LSB  = 24;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [CAP_W-1:0]  CAP_DEFAULT    = 4'hf;  // entries minus one: full depth
  localparam logic [DATA_W-1:0] IDENT_VALUE    = 32'h0000_5a01;  // arbitrary value
  localparam logic [DATA_W-1:0] RESERVED_VALUE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD      = 32'h0000_0000;

endpackage : regsem_pkg

// ### tb/host_model.sv
// host cpu model issuing single-word register accesses
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // host bus
  input  wire logic        clk,
  output logic [5:0]       addr,
  output logic             rd,
  output logic             wr,
  output logic [31:0]      wdata,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid
);
  // idle bus from time zero
  initial {addr, rd, wr, wdata} = '0;
  // callers send zero in reserved bits and use mapped addresses only
  task automatic write(input logic [5:0] a, input logic [31:0] d);
    @(negedge clk) {addr, wr, wdata} = {a, 1'b1, d};
    @(negedge clk) {addr, wr, wdata} = {~a, 1'b0, ~d};
  endtask : write
  // a missing answer comes back unknown so it never matches
  task automatic read(input logic [5:0] a, output logic [31:0] d);
    @(negedge clk) {addr, rd} = {a, 1'b1};
    @(negedge clk) d = (rvalid === 1'b1) ? rdata : 'x;
    {addr, rd} = {~a, 1'b0};
  endtask : read
endmodule : host_model
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock = 1'b0;
  logic        reset, link_up, fault, rxs_v, rxd_v, host_rd, host_wr, rvalid, soft_rst, rxd_rdy, txd_v;
  logic        txs_v, txd_rdy;
  logic [3:0]  ev_w1c, ev_rc;
  logic [5:0]  host_addr;
  logic [31:0] wdata, rdata, rx_data, got, cmd_w, ret_w, txd_data;
  int          num_errors = 0, comparisons = 0;
  host_model u_host (.clk(clock), .addr(host_addr), .rd(host_rd), .wr(host_wr), .wdata(wdata), .rdata(rdata),
    .rvalid(rvalid));
  regsem_bank u_dut (.CLOCK(clock), .RESET(reset), .HOST_ADDR(host_addr), .HOST_RD(host_rd), .HOST_WR(host_wr),
    .HOST_WDATA(wdata), .HOST_RDATA(rdata), .HOST_RVALID(rvalid), .RXS_VALID(rxs_v), .RXS_DATA(rx_data),
    .RXS_READY(), .RXD_VALID(rxd_v), .RXD_DATA(rx_data), .RXD_READY(rxd_rdy), .TXS_VALID(txs_v),
    .TXS_DATA(rx_data), .TXS_READY(), .TXD_VALID(txd_v), .TXD_DATA(txd_data), .TXD_READY(txd_rdy),
    .LINK_UP(link_up), .FAULT(fault), .EVENT_W1C(ev_w1c), .EVENT_RC(ev_rc), .COMMAND_WORD(cmd_w),
    .RETAINED_WORD(ret_w), .SOFT_RESET(soft_rst));
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    num_errors += int'(g !== e);
    if (g !== e) $display("Error at %0t: got %h, expected %h", $time, g, e);
  endtask : chk
  // table step: bit 38 write, bits 37:32 address, else read and compare
  task automatic step(input logic [38:0] s);
    if (s[38]) u_host.write(s[37:32], s[31:0]);
    else begin
      u_host.read(s[37:32], got);
      chk(got, s[31:0]);
    end
  endtask : step
  // one word into a queue; one-hot select: bit0 receive status, bit1 receive data, bit2 transmit status
  task automatic push(input logic [2:0] s, input logic [31:0] d);
    @(negedge clock) {txs_v, rxd_v, rxs_v, rx_data} = {s, d};
    @(negedge clock) {txs_v, rxd_v, rxs_v, rx_data} = {3'b000, ~d};
  endtask : push
  // pulse the status pins, then poke every field kind
  task automatic t_fields();
    logic [38:0] ops [10] = '{39'h64_0000_1234, 39'h24_0000_5a01, 39'h6a_0000_00a5, 39'h2a_0000_0000,
      39'h67_0000_0001, 39'h27_0000_0004, 39'h28_0000_0003, 39'h28_0000_0000, 39'h29_0000_0002, 39'h29_0000_0001};
    {ev_w1c, ev_rc, link_up, fault} = 10'h14d;
    repeat (4) @(negedge clock);
    {ev_w1c, ev_rc, link_up, fault} = 10'h002;
    repeat (4) @(negedge clock);
    foreach (ops[i]) step(ops[i]);
  endtask : t_fields
  // peek keeps the head, pop removes it, transmit data through an alias
  task automatic t_queues();
    logic [38:0] ops [11] = '{39'h2b_0001_0102, 39'h60_0000_0099, 39'h21_0000_0011, 39'h20_0000_0011,
      39'h21_0000_0022, 39'h23_0000_0033, 39'h22_0000_0033, 39'h23_0000_0000, 39'h0f_0000_0044,
      39'h03_0000_0000, 39'h5b_0000_0055};
    push(3'b001, 32'h0000_0011);
    push(3'b001, 32'h0000_0022);
    push(3'b100, 32'h0000_0033);
    push(3'b010, 32'h0000_0044);
    foreach (ops[i]) step(ops[i]);
    chk(txd_v ? txd_data : 'x, 32'h0000_0055);
    @(negedge clock) txd_rdy = 1'b1;
    @(negedge clock) txd_rdy = 1'b0;
    chk(32'(txd_v), 32'h0000_0000);
  endtask : t_queues
  // one-entry data cap, then soft reset restores defaults but keeps the retained word
  task automatic t_soft();
    step(39'h65_0000_ff00);
    push(3'b010, 32'h0000_0077);
    chk(32'(rxd_rdy), 32'h0000_0000);
    step(39'h66_0000_00c3);
    step(39'h65_0000_ff01);
    chk(32'(soft_rst), 32'h0000_0001);
    repeat (2) @(negedge clock);
    chk(32'(soft_rst), 32'h0000_0000);
    chk(ret_w, 32'h0000_00c3);
    chk(cmd_w, 32'h0000_0000);
    step(39'h25_0000_fff0);
    chk(32'(rxd_rdy), 32'h0000_0001);
  endtask : t_soft
  // verdict and stop
  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // 40 MHz clock
  initial forever #12.5 clock = ~clock;
  // reset for ten cycles, then the scenarios
  initial begin
    {reset, link_up} = 2'b11;
    {fault, rxs_v, rxd_v, txs_v, txd_rdy, ev_w1c, ev_rc, rx_data} = '0;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    t_fields();
    t_queues();
    t_soft();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
